// File: rtl/fixed_point_alu_regs.vh
`ifndef FIXED_POINT_ALU_REGS_VH
`define FIXED_POINT_ALU_REGS_VH

// Register byte offsets on the AXI4-Lite slave
`define OFS_CONFIG        8'h00
`define OFS_ACCUM         8'h04
`define OFS_PRODUCT       8'h08
`define OFS_FLAGS         8'h0c
`define OFS_HOLD          8'h10

// Field positions in the configuration word (status_word_one)
`define CFG_SIGN_FILL_BIT 0
`define CFG_SCALE_LO      2
`define CFG_SCALE_HI      3

// Field positions in the flags word
`define FLG_CARRY_BIT     0
`define FLG_BIT_TEST_BIT  1
`define FLG_NORM_DONE_BIT 2

// Reset values
`define RST_CONFIG        32'h0000_0000
`define RST_ACCUM         32'h0000_0000
`define RST_PRODUCT       32'h0000_0000
`define RST_HOLD          16'h0000

// Product shift modes (product_scale_code)
`define PSC_NONE          2'h0
`define PSC_LEFT1         2'h1
`define PSC_LEFT4         2'h2
`define PSC_RIGHT6        2'h3

// Largest input scaling shift
`define MAX_SCALE_SHIFT   5'h10

// Decoder operation codes
`define OP_NOP            4'h0
`define OP_LOAD           4'h1
`define OP_ADD            4'h2
`define OP_SUB            4'h3
`define OP_AND            4'h4
`define OP_OR             4'h5
`define OP_XOR            4'h6
`define OP_LOAD_HOLD      4'h7
`define OP_MPY            4'h8
`define OP_MAC            4'h9
`define OP_STORE_HI       4'ha
`define OP_STORE_LO       4'hb
`define OP_BRANCH_ACC     4'hc
`define OP_NORM           4'hd
`define OP_BIT_TEST       4'he

// AXI response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// File: rtl/input_scaler.v
`include "fixed_point_alu_regs.vh"

module input_scaler (
  // Data bus word and shift control
  input  wire [15:0] data_in,
  input  wire [4:0]  shift_amt,
  input  wire        sign_fill_select,
  // Scaled operand
  output wire [31:0] scaled_out
);

  wire [4:0]  amt_clamped;
  wire [31:0] extended;

  // Amounts above sixteen are clamped rather than wrapped
  assign amt_clamped = (shift_amt > `MAX_SCALE_SHIFT) ?
                       `MAX_SCALE_SHIFT : shift_amt;
  assign extended    = sign_fill_select ? {{16{data_in[15]}}, data_in}
                                        : {16'h0000, data_in};
  assign scaled_out  = extended << amt_clamped;

endmodule // input_scaler

// File: rtl/product_scaler.v
`include "fixed_point_alu_regs.vh"

module product_scaler (
  // Product register and mode
  input  wire [31:0] product_in,
  input  wire [1:0]  product_scale_code,
  // Shifted product
  output reg  [31:0] product_out
);

  always @* begin
    case (product_scale_code)
      `PSC_NONE:   product_out = product_in;
      `PSC_LEFT1:  product_out = {product_in[30:0], 1'b0};
      `PSC_LEFT4:  product_out = {product_in[27:0], 4'h0};
      `PSC_RIGHT6: product_out = {{6{product_in[31]}}, product_in[31:6]};
      default:     product_out = product_in;
    endcase
  end

endmodule // product_scaler

// File: rtl/fixed_point_alu.v
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "fixed_point_alu_regs.vh"

module fixed_point_alu (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Instruction decoder controls
  input  wire        op_valid,
  input  wire [3:0]  op_code,
  input  wire [4:0]  scale_shift,
  input  wire        src_is_product,
  input  wire        mul_signed,
  input  wire [2:0]  store_shift,
  input  wire [3:0]  bit_select,
  // On-chip buses
  input  wire [15:0] data_bus_in,
  input  wire [15:0] prog_bus_in,
  output reg  [15:0] data_bus_out,
  output reg         data_bus_out_en,
  // Branch and flag results
  output reg  [15:0] branch_target,
  output reg         branch_valid,
  output reg         bit_test_flag,
  output reg         carry_flag,
  output reg         norm_done,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp
);

  reg  [31:0] upper_lower_acc_q;
  reg  [31:0] multiplier_result_reg_q;
  reg  [15:0] multiplier_operand_hold_q;
  reg  [31:0] status_word_one_q;
  reg  [7:0]  aw_addr_q;
  reg         aw_full_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_full_q;

  wire        sign_fill_select;
  wire [1:0]  product_scale_code;
  wire [15:0] upper_sum_half;
  wire [15:0] lower_sum_half;
  wire [31:0] scaled_operand;
  wire [31:0] product_shifted;
  wire [31:0] alu_operand;
  wire [32:0] add_result;
  wire [32:0] sub_result;
  wire [31:0] store_shifted;
  wire [15:0] mul_b;
  wire [15:0] mul_a;
  wire [16:0] mul_a_ext;
  wire [16:0] mul_b_ext;
  wire [33:0] mul_full;
  wire        exec;
  wire        wr_fire;
  wire        rd_fire;

  assign sign_fill_select   = status_word_one_q[`CFG_SIGN_FILL_BIT];
  assign product_scale_code =
    status_word_one_q[`CFG_SCALE_HI:`CFG_SCALE_LO];
  assign upper_sum_half     = upper_lower_acc_q[31:16];
  assign lower_sum_half     = upper_lower_acc_q[15:0];
  assign exec               = op_valid;

  input_scaler u_input_scaler (
    .data_in          (data_bus_in),
    .shift_amt        (scale_shift),
    .sign_fill_select (sign_fill_select),
    .scaled_out       (scaled_operand)
  );

  product_scaler u_product_scaler (
    .product_in         (multiplier_result_reg_q),
    .product_scale_code (product_scale_code),
    .product_out        (product_shifted)
  );

  // Multiply-accumulate always adds the product, whatever the source select
  assign alu_operand = (src_is_product || op_code == `OP_MAC) ?
                       product_shifted : scaled_operand;
  assign add_result  = {1'b0, upper_lower_acc_q}
                     + {1'b0, alu_operand};
  // Carry on subtract is the inverted borrow, as in a two's complement adder
  assign sub_result  = {1'b0, upper_lower_acc_q}
                     + {1'b0, ~alu_operand} + 33'h0_0000_0001;

  // Multiply-accumulate reads program bus and data bus in one cycle
  assign mul_a     = (op_code == `OP_MAC) ? prog_bus_in
                                          : multiplier_operand_hold_q;
  assign mul_b     = data_bus_in;
  assign mul_a_ext = {mul_signed & mul_a[15], mul_a};
  assign mul_b_ext = {mul_signed & mul_b[15], mul_b};
  assign mul_full  = $signed(mul_a_ext) * $signed(mul_b_ext);

  assign store_shifted = upper_lower_acc_q << store_shift;

  // Datapath
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      upper_lower_acc_q         <= `RST_ACCUM;
      multiplier_result_reg_q   <= `RST_PRODUCT;
      multiplier_operand_hold_q <= `RST_HOLD;
      carry_flag                <= 1'b0;
      bit_test_flag             <= 1'b0;
      norm_done                 <= 1'b0;
      data_bus_out              <= 16'h0000;
      data_bus_out_en           <= 1'b0;
      branch_target             <= 16'h0000;
      branch_valid              <= 1'b0;
    end else begin
      data_bus_out_en <= 1'b0;
      branch_valid    <= 1'b0;
      // Software may preload the hold register; the decoder wins a tie
      if (wr_fire && aw_addr_q == `OFS_HOLD) begin
        if (w_strb_q[0]) multiplier_operand_hold_q[7:0]  <= w_data_q[7:0];
        if (w_strb_q[1]) multiplier_operand_hold_q[15:8] <= w_data_q[15:8];
      end
      if (exec) begin
        case (op_code)
          `OP_LOAD: upper_lower_acc_q <= alu_operand;
          `OP_ADD: begin
            upper_lower_acc_q <= add_result[31:0];
            carry_flag        <= add_result[32];
          end
          `OP_SUB: begin
            upper_lower_acc_q <= sub_result[31:0];
            carry_flag        <= sub_result[32];
          end
          `OP_AND: upper_lower_acc_q <= upper_lower_acc_q & alu_operand;
          `OP_OR:  upper_lower_acc_q <= upper_lower_acc_q | alu_operand;
          `OP_XOR: upper_lower_acc_q <= upper_lower_acc_q ^ alu_operand;
          `OP_LOAD_HOLD:
            multiplier_operand_hold_q <= data_bus_in;
          `OP_MPY:
            multiplier_result_reg_q <= mul_full[31:0];
          `OP_MAC: begin
            upper_lower_acc_q         <= add_result[31:0];
            carry_flag                <= add_result[32];
            multiplier_operand_hold_q <= data_bus_in;
            multiplier_result_reg_q   <= mul_full[31:0];
          end
          `OP_STORE_HI: begin
            data_bus_out    <= store_shifted[31:16];
            data_bus_out_en <= 1'b1;
          end
          `OP_STORE_LO: begin
            data_bus_out    <= store_shifted[15:0];
            data_bus_out_en <= 1'b1;
          end
          `OP_BRANCH_ACC: begin
            branch_target <= lower_sum_half;
            branch_valid  <= 1'b1;
          end
          `OP_NORM: begin
            // One step per op; decoder repeats until norm_done is set
            if (upper_lower_acc_q[31] != upper_lower_acc_q[30] ||
                upper_lower_acc_q == 32'h0000_0000) begin
              norm_done <= 1'b1;
            end else begin
              upper_lower_acc_q <= {upper_lower_acc_q[30:0], 1'b0};
              norm_done         <= 1'b0;
            end
          end
          `OP_BIT_TEST: bit_test_flag <= data_bus_in[bit_select];
          default: ;
        endcase
      end
    end
  end

  // AXI4-Lite slave: address and data are taken in either order
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid & ~s_axi_rvalid;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_addr_q         <= 8'h00;
      aw_full_q         <= 1'b0;
      w_data_q          <= 32'h0000_0000;
      w_strb_q          <= 4'h0;
      w_full_q          <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `RESP_OKAY;
      s_axi_rvalid      <= 1'b0;
      s_axi_rdata       <= 32'h0000_0000;
      s_axi_rresp       <= `RESP_OKAY;
      status_word_one_q <= `RST_CONFIG;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_addr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_q)
          `OFS_CONFIG:
            if (w_strb_q[0]) begin
              status_word_one_q[`CFG_SIGN_FILL_BIT] <=
                w_data_q[`CFG_SIGN_FILL_BIT];
              status_word_one_q[`CFG_SCALE_HI:`CFG_SCALE_LO] <=
                w_data_q[`CFG_SCALE_HI:`CFG_SCALE_LO];
            end
          `OFS_HOLD: ;
          `OFS_ACCUM, `OFS_PRODUCT, `OFS_FLAGS: ;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_CONFIG:  s_axi_rdata <= status_word_one_q;
          `OFS_ACCUM:   s_axi_rdata <= {upper_sum_half, lower_sum_half};
          `OFS_PRODUCT: s_axi_rdata <= multiplier_result_reg_q;
          `OFS_FLAGS:   s_axi_rdata <= {29'h0000_0000, norm_done,
                                        bit_test_flag, carry_flag};
          `OFS_HOLD:    s_axi_rdata <= {16'h0000, multiplier_operand_hold_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // fixed_point_alu

// File: testbench/fixed_point_alu_monitor.sv
`include "fixed_point_alu_regs.vh"

module fixed_point_alu_monitor (
  // Clock and decoder side
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        op_valid,
  input wire logic [3:0]  op_code,
  input wire logic [3:0]  bit_select,
  input wire logic [15:0] data_bus_in,
  // Results
  input wire logic        data_bus_out_en,
  input wire logic        branch_valid,
  input wire logic        bit_test_flag,
  input wire logic        carry_flag,
  // Bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit chosen one cycle back, since $past takes only plain signals
  logic bit_exp_q;
  always_ff @(posedge clk_sys) bit_exp_q <= data_bus_in[bit_select];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_store;
    op_valid && (op_code == `OP_STORE_HI || op_code == `OP_STORE_LO);
  endsequence
  sequence s_branch;
    op_valid && op_code == `OP_BRANCH_ACC;
  endsequence
  property p_store_en; s_store |=> data_bus_out_en; endproperty
  property p_en_cause;
    data_bus_out_en |-> $past(op_valid) && ($past(op_code) == `OP_STORE_HI
      || $past(op_code) == `OP_STORE_LO);
  endproperty
  property p_branch; s_branch |=> branch_valid; endproperty
  property p_branch_cause;
    branch_valid |-> $past(op_valid) && $past(op_code) == `OP_BRANCH_ACC;
  endproperty
  property p_bit_test;
    op_valid && op_code == `OP_BIT_TEST |=> bit_test_flag == bit_exp_q;
  endproperty
  property p_bit_hold;
    !$stable(bit_test_flag) |-> $past(op_valid)
      && $past(op_code) == `OP_BIT_TEST;
  endproperty
  property p_carry_hold;
    !$stable(carry_flag) |-> $past(op_valid) && $past(op_code)
      inside {`OP_ADD, `OP_SUB, `OP_MAC};
  endproperty
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_store_en: assert property (p_store_en) else $error("no store pulse");
  a_en_cause: assert property (p_en_cause) else $error("stray store");
  a_branch: assert property (p_branch) else $error("no branch pulse");
  a_branch_cause: assert property (p_branch_cause) else $error("stray br");
  a_bit_test: assert property (p_bit_test) else $error("bit test wrong");
  a_bit_hold: assert property (p_bit_hold) else $error("bit flag moved");
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved");
  a_bresp_hold: assert property (p_bresp_hold) else $error("bresp dropped");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata dropped");
endmodule // fixed_point_alu_monitor

bind fixed_point_alu fixed_point_alu_monitor i_fixed_point_alu_monitor (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .bit_select(bit_select), .data_bus_in(data_bus_in),
  .data_bus_out_en(data_bus_out_en), .branch_valid(branch_valid),
  .bit_test_flag(bit_test_flag), .carry_flag(carry_flag),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// File: testbench/decoder_model.sv
module decoder_model (
  // Clock
  input  wire logic clk_sys,
  // Decoder controls and buses
  output logic        op_valid       = 1'b0,
  output logic [3:0]  op_code        = 4'h0,
  output logic [4:0]  scale_shift    = 5'h00,
  output logic        src_is_product = 1'b0,
  output logic        mul_signed     = 1'b0,
  output logic [2:0]  store_shift    = 3'h0,
  output logic [3:0]  bit_select     = 4'h0,
  output logic [15:0] data_bus_in    = 16'h0000,
  output logic [15:0] prog_bus_in    = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both bus words arrive in the same cycle as the operation
  task automatic issue(input [3:0] c, input [15:0] d, p, input [4:0] s,
                       input [2:0] x, input m, r, input [3:0] b);
    @(posedge clk_sys);
    op_code <= c;
    data_bus_in <= d;
    prog_bus_in <= p;
    scale_shift <= s;
    store_shift <= x;
    mul_signed <= m;
    src_is_product <= r;
    bit_select <= b;
    op_valid <= 1'b1;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    // Released buses never keep the old word, so stale use shows
    data_bus_in <= ~d;
    prog_bus_in <= ~p;
    #1;
  endtask
endmodule // decoder_model

// File: testbench/tb_fixed_point_alu.sv
`include "fixed_point_alu_regs.vh"

module tb_fixed_point_alu;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, sys_rst = 1, op_valid, src_is_product, mul_signed;
  logic [3:0] op_code, bit_select;
  logic [4:0] scale_shift;
  logic [2:0] store_shift;
  logic [15:0] data_bus_in, prog_bus_in, data_bus_out, branch_target;
  logic data_bus_out_en, branch_valid, bit_test_flag, carry_flag, norm_done;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] mode [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [31:0] pexp [4] = '{32'h0005fff4, 32'h002fffa0, 32'h00000bff,
                            32'h0002fffa};
  int n_errors = 0, compares = 0;
  fixed_point_alu i_fixed_point_alu (.*);
  decoder_model i_decoder_model (.*);
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Answer ready is raised only after the answer shows, to exercise holding
  task automatic axw(input [7:0] a, input [31:0] d);
    logic at, wt, bt;
    @(posedge clk_sys);
    s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1; s_axi_wdata <= d;
    forever begin
      @(negedge clk_sys);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid && s_axi_bready;
      if (bt) chk(s_axi_bresp, `RESP_OKAY);
      @(posedge clk_sys);
      if (at) s_axi_awvalid <= 0;
      if (wt) s_axi_wvalid <= 0;
      if (bt) begin
        s_axi_bready <= 0;
        break;
      end
      if (s_axi_bvalid) s_axi_bready <= 1;
    end
  endtask
  task automatic axr(input [7:0] a, input [31:0] e, input [1:0] rp);
    logic at, rt;
    @(posedge clk_sys);
    s_axi_arvalid <= 1; s_axi_araddr <= a;
    forever begin
      @(negedge clk_sys);
      at = s_axi_arvalid && s_axi_arready;
      rt = s_axi_rvalid && s_axi_rready;
      if (rt) chk(s_axi_rdata, e);
      if (rt) chk(s_axi_rresp, rp);
      @(posedge clk_sys);
      if (at) s_axi_arvalid <= 0;
      if (rt) begin
        s_axi_rready <= 0;
        break;
      end
      if (s_axi_rvalid) s_axi_rready <= 1;
    end
  endtask
  initial begin
    #40000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 0;
    axr(`OFS_CONFIG, `RST_CONFIG, `RESP_OKAY);
    axr(`OFS_HOLD, 32'h0, `RESP_OKAY);
    axw(`OFS_CONFIG, 32'h1);
    i_decoder_model.issue(`OP_LOAD, 16'h8001, 0, 4, 0, 1, 0, 0);
    axr(`OFS_ACCUM, 32'hfff80010, `RESP_OKAY);
    i_decoder_model.issue(`OP_STORE_HI, 0, 0, 0, 0, 1, 0, 0);
    chk(data_bus_out, 16'hfff8);
    chk(data_bus_out_en, 1);
    i_decoder_model.issue(`OP_STORE_LO, 0, 0, 0, 4, 1, 0, 0);
    chk(data_bus_out, 16'h0100);
    i_decoder_model.issue(`OP_BRANCH_ACC, 0, 0, 0, 0, 1, 0, 0);
    chk(branch_target, 16'h0010);
    axr(`OFS_ACCUM, 32'hfff80010, `RESP_OKAY);
    i_decoder_model.issue(`OP_ADD, 16'h0010, 0, 0, 0, 1, 0, 0);
    i_decoder_model.issue(`OP_ADD, 16'h0008, 0, 16, 0, 1, 0, 0);
    chk(carry_flag, 1);
    axr(`OFS_ACCUM, 32'h20, `RESP_OKAY);
    i_decoder_model.issue(`OP_SUB, 16'h0030, 0, 0, 0, 1, 0, 0);
    chk(carry_flag, 0);
    i_decoder_model.issue(`OP_LOAD_HOLD, 16'hfffe, 0, 0, 0, 1, 0, 0);
    i_decoder_model.issue(`OP_MPY, 16'h0003, 0, 0, 0, 1, 0, 0);
    axr(`OFS_PRODUCT, 32'hfffffffa, `RESP_OKAY);
    i_decoder_model.issue(`OP_MPY, 16'h0003, 0, 0, 0, 0, 0, 0);
    axr(`OFS_PRODUCT, 32'h0002fffa, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      axw(`OFS_CONFIG, {28'h0, mode[i], 2'h0});
      i_decoder_model.issue(`OP_LOAD, 0, 0, 0, 0, 0, 1, 0);
      axr(`OFS_ACCUM, pexp[i], `RESP_OKAY);
    end
    i_decoder_model.issue(`OP_MAC, 16'h0005, 16'h0002, 0, 0, 1, 1, 0);
    axr(`OFS_ACCUM, 32'h0005fff4, `RESP_OKAY);
    axr(`OFS_PRODUCT, 32'h0000000a, `RESP_OKAY);
    axr(`OFS_HOLD, 32'h00000005, `RESP_OKAY);
    i_decoder_model.issue(`OP_BIT_TEST, 16'h0020, 0, 0, 0, 1, 0, 5);
    chk(bit_test_flag, 1);
    i_decoder_model.issue(`OP_BIT_TEST, 16'h0020, 0, 0, 0, 1, 0, 4);
    chk(bit_test_flag, 0);
    // Twelve shifts bring the leading one up, the next op reports done
    repeat (16) if (norm_done !== 1'b1)
      i_decoder_model.issue(`OP_NORM, 0, 0, 0, 0, 1, 0, 0);
    chk(norm_done, 1);
    axr(`OFS_ACCUM, 32'h5fff4000, `RESP_OKAY);
    // Logic ops leave the carry alone, so the flags read below still holds
    i_decoder_model.issue(`OP_AND, 16'h0ff0, 0, 0, 0, 1, 0, 0);
    axr(`OFS_ACCUM, 32'h0, `RESP_OKAY);
    i_decoder_model.issue(`OP_OR, 16'h1234, 0, 0, 0, 1, 0, 0);
    i_decoder_model.issue(`OP_XOR, 16'h0034, 0, 0, 0, 1, 0, 0);
    axr(`OFS_ACCUM, 32'h00001200, `RESP_OKAY);
    axw(`OFS_HOLD, 32'h00001357);
    axr(`OFS_HOLD, 32'h00001357, `RESP_OKAY);
    axr(`OFS_FLAGS, 32'h4, `RESP_OKAY);
    axr(8'h20, 32'h0, `RESP_SLVERR);
    finish_test();
  end
endmodule // tb_fixed_point_alu
